//--- rtl/trb_top.sv
// Top: button detection with hysteresis, report arbitration, level PWM outputs and buzzer.
// Assumes tick counts and scan strobe come from logic on sys_clk; config held static by user.
// Overview of operation
// - Button touched when tick count reaches threshold plus hysteresis.
// - Touched button released when tick count falls below threshold minus hysteresis.
// - New touch drives buzzer square wave about 30ms total by default.
// - Default tone: 15ms at 4kHz then 15ms at 8kHz.
// - Buzzer sounds once per touch, never repeats while held.
// - Buzzer enable, idle level, frequencies and durations are configurable.
// - Level PWM duty is idle level when nothing reported, else button level.
// - Each button has its own configured level index.
// - Level PWM generators are 8-bit counters clocked at 2MHz.
// - PWM period selectable 256 default or 64 counts.
// - Index 0 gives width 0, index n gives n+1 counts.
// - With 64-count period only indices 0 to 63 are valid.
// - At most one button reported on level outputs at a time.
// - Each button mappable to output A, B or both; A pin7, B pin6.
// - All mode flags every touched button in status bits.
// - First mode reports first touch, ignores others until it releases.
// - Simultaneous first-mode touches report lowest sensor index.
// - On release, remaining button reported immediately or after one idle scan.
// - Strongest mode replaces report only with a stronger touched button.
// - Strongest mode keeps stronger button on weaker release; idle when none.
// - After forced interval, output returns to idle one scan or button level.
// - Touch states, report and status outputs update only once per scan in processing phase.
`timescale 1ns/1ps
module trb_top (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic scan_strobe,
   input wire logic [trb_pkg::NUM_BTN*trb_pkg::TICK_W-1:0] sensor_ticks,
   input wire logic [trb_pkg::TICK_W-1:0] threshold,
   input wire logic [trb_pkg::TICK_W-1:0] hysteresis,
   input wire logic [trb_pkg::NUM_BTN*8-1:0] button_level_index,
   input wire logic [trb_pkg::NUM_BTN-1:0] map_a,
   input wire logic [trb_pkg::NUM_BTN-1:0] map_b,
   input wire trb_pkg::trb_lvl_cfg_s lvl_cfg,
   input wire trb_pkg::trb_buz_cfg_s buz_cfg,
   output logic [trb_pkg::NUM_BTN-1:0] button_status,
   output logic report_valid,
   output logic [2:0] report_index,
   output logic level_a_pin,
   output logic level_b_pin,
   output logic buzzer_pin
);
   localparam int NB = trb_pkg::NUM_BTN;
   localparam int TW = trb_pkg::TICK_W;

   // ----------------------------------------
   // Touch detection with hysteresis
   // ----------------------------------------
   logic [NB-1:0] touched_r;
   logic [NB-1:0] touched_nxt;
   logic [TW:0] on_lvl;
   logic [TW:0] off_lvl;
   logic [TW-1:0] tick_of [NB];

   always_comb
   begin
      on_lvl = {1'b0, threshold} + {1'b0, hysteresis};
      off_lvl = (threshold > hysteresis) ? {1'b0, threshold - hysteresis} : '0;
   end

   genvar gi;
   generate
      for (gi = 0; gi < NB; gi++)
      begin : g_btn
         assign tick_of[gi] = sensor_ticks[gi*TW +: TW];
         always_comb
         begin
            touched_nxt[gi] = touched_r[gi];
            if (scan_strobe)
            begin
               if (!touched_r[gi] && {1'b0, tick_of[gi]} >= on_lvl)
                  touched_nxt[gi] = 1'b1;
               else if (touched_r[gi] && {1'b0, tick_of[gi]} < off_lvl)
                  touched_nxt[gi] = 1'b0;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Report arbitration
   // ----------------------------------------
   logic rep_v_r;
   logic rep_v_nxt;
   logic [2:0] rep_i_r;
   logic [2:0] rep_i_nxt;
   logic gap_r;
   logic gap_nxt;
   logic [NB-1:0] status_r;
   logic [NB-1:0] status_nxt;
   logic any_nxt;
   logic [2:0] low_i;
   logic [2:0] strong_i;
   logic [TW-1:0] strong_t;
   logic [NB-1:0] new_touch;

   always_comb
   begin
      any_nxt = |touched_nxt;
      low_i = 3'h0;
      strong_i = 3'h0;
      strong_t = '0;
      for (int i = NB - 1; i >= 0; i--)
      begin
         if (touched_nxt[i])
            low_i = 3'(i);
      end
      for (int i = 0; i < NB; i++)
      begin
         if (touched_nxt[i] && (tick_of[i] > strong_t || strong_i == 3'(i)))
         begin
            strong_i = 3'(i);
            strong_t = tick_of[i];
         end
      end
      rep_v_nxt = rep_v_r;
      rep_i_nxt = rep_i_r;
      gap_nxt = gap_r;
      status_nxt = status_r;
      if (scan_strobe)
      begin
         gap_nxt = 1'b0;
         if (!any_nxt)
            rep_v_nxt = 1'b0;
         else if (lvl_cfg.report_mode == trb_pkg::MODE_STRONG)
         begin
            if (!rep_v_r || !touched_nxt[rep_i_r])
            begin
               // Replacement after release may pass one idle scan
               rep_v_nxt = !(rep_v_r && lvl_cfg.idle_gap);
               rep_i_nxt = strong_i;
            end
            else if (tick_of[strong_i] > tick_of[rep_i_r])
            begin
               rep_v_nxt = !lvl_cfg.idle_gap;
               rep_i_nxt = strong_i;
            end
         end
         else
         begin
            if (!rep_v_r)
            begin
               // A pending gap scan has already shown idle, so report now
               rep_v_nxt = 1'b1;
               rep_i_nxt = low_i;
            end
            else if (!touched_nxt[rep_i_r])
            begin
               rep_v_nxt = !lvl_cfg.idle_gap;
               rep_i_nxt = low_i;
            end
         end
         if (rep_v_r && !rep_v_nxt && any_nxt)
            gap_nxt = 1'b1;
         if (lvl_cfg.report_mode == trb_pkg::MODE_ALL)
            status_nxt = touched_nxt;
         else
         begin
            status_nxt = '0;
            if (rep_v_nxt)
               status_nxt[rep_i_nxt] = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         touched_r <= '0;
         rep_v_r <= 1'b0;
         rep_i_r <= 3'h0;
         gap_r <= 1'b0;
         status_r <= '0;
      end
      else
      begin
         touched_r <= touched_nxt;
         rep_v_r <= rep_v_nxt;
         rep_i_r <= rep_i_nxt;
         gap_r <= gap_nxt;
         status_r <= status_nxt;
      end
   end

   // ----------------------------------------
   // Buzzer
   // ----------------------------------------
   trb_pkg::trb_buz_e bz_r;
   trb_pkg::trb_buz_e bz_nxt;
   logic [trb_pkg::BUZ_CNT_W-1:0] bz_dur_r;
   logic [trb_pkg::BUZ_CNT_W-1:0] bz_dur_nxt;
   logic [trb_pkg::BUZ_CNT_W-1:0] bz_half_r;
   logic [trb_pkg::BUZ_CNT_W-1:0] bz_half_nxt;
   logic bz_out_r;
   logic bz_out_nxt;
   logic bz_done_r;
   logic bz_done_nxt;

   always_comb
   begin
      // New touch is a rising touched state, so a held button never retriggers
      new_touch = touched_nxt & ~touched_r;
      bz_nxt = bz_r;
      bz_dur_nxt = bz_dur_r;
      bz_half_nxt = bz_half_r;
      bz_out_nxt = bz_out_r;
      bz_done_nxt = 1'b0;
      case (bz_r)
         trb_pkg::BZ_IDLE:
         begin
            bz_out_nxt = buz_cfg.idle_level;
            if (scan_strobe && |new_touch && buz_cfg.enable)
            begin
               bz_nxt = trb_pkg::BZ_PH1;
               bz_dur_nxt = buz_cfg.dur1;
               bz_half_nxt = buz_cfg.half1;
               bz_out_nxt = ~buz_cfg.idle_level;
            end
         end
         trb_pkg::BZ_PH1, trb_pkg::BZ_PH2:
         begin
            bz_dur_nxt = bz_dur_r - 1'b1;
            bz_half_nxt = bz_half_r - 1'b1;
            if (bz_half_r <= 1)
            begin
               bz_out_nxt = ~bz_out_r;
               bz_half_nxt = (bz_r == trb_pkg::BZ_PH1) ? buz_cfg.half1 : buz_cfg.half2;
            end
            if (bz_dur_r <= 1)
            begin
               if (bz_r == trb_pkg::BZ_PH1)
               begin
                  bz_nxt = trb_pkg::BZ_PH2;
                  bz_dur_nxt = buz_cfg.dur2;
                  bz_half_nxt = buz_cfg.half2;
               end
               else
               begin
                  bz_nxt = trb_pkg::BZ_IDLE;
                  bz_out_nxt = buz_cfg.idle_level;
                  bz_done_nxt = 1'b1;
               end
            end
         end
         default:
            bz_nxt = trb_pkg::BZ_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bz_r <= trb_pkg::BZ_IDLE;
         bz_dur_r <= '0;
         bz_half_r <= '0;
         bz_out_r <= 1'b0;
         bz_done_r <= 1'b0;
      end
      else
      begin
         bz_r <= bz_nxt;
         bz_dur_r <= bz_dur_nxt;
         bz_half_r <= bz_half_nxt;
         bz_out_r <= bz_out_nxt;
         bz_done_r <= bz_done_nxt;
      end
   end

   // ----------------------------------------
   // Level outputs
   // ----------------------------------------
   logic [trb_pkg::PWM_DIV_W-1:0] div_r;
   logic [trb_pkg::PWM_DIV_W-1:0] div_nxt;
   logic tick;
   logic post_gap_r;
   logic post_gap_nxt;
   logic [7:0] idx_a;
   logic [7:0] idx_b;
   logic [7:0] btn_idx;
   logic pwm_a;
   logic pwm_b;
   logic lvl_a_r;
   logic lvl_b_r;
   logic lvl_a_nxt;
   logic lvl_b_nxt;
   logic forcing;

   always_comb
   begin
      tick = (div_r == trb_pkg::PWM_DIV_W'(trb_pkg::PWM_DIV - 1));
      div_nxt = tick ? '0 : div_r + 1'b1;
      btn_idx = button_level_index[rep_i_r*8 +: 8];
      if (lvl_cfg.period_64 && btn_idx > trb_pkg::PER64_MAX)
         btn_idx = trb_pkg::PER64_MAX;
      // After a forced interval, one idle scan may be inserted
      post_gap_nxt = post_gap_r;
      if (bz_done_r && lvl_cfg.force_mode != trb_pkg::FORCE_NONE && lvl_cfg.idle_gap)
         post_gap_nxt = 1'b1;
      else if (scan_strobe)
         post_gap_nxt = 1'b0;
      idx_a = lvl_cfg.idle_index;
      idx_b = lvl_cfg.idle_index;
      if (rep_v_r && !post_gap_r)
      begin
         if (map_a[rep_i_r])
            idx_a = btn_idx;
         if (map_b[rep_i_r])
            idx_b = btn_idx;
      end
      forcing = (bz_r != trb_pkg::BZ_IDLE) && lvl_cfg.force_mode != trb_pkg::FORCE_NONE;
      if (forcing && lvl_cfg.force_mode == trb_pkg::FORCE_IDLE)
      begin
         idx_a = lvl_cfg.idle_index;
         idx_b = lvl_cfg.idle_index;
      end
      lvl_a_nxt = pwm_a;
      lvl_b_nxt = pwm_b;
      if (forcing && lvl_cfg.force_mode != trb_pkg::FORCE_IDLE)
      begin
         lvl_a_nxt = (lvl_cfg.force_mode == trb_pkg::FORCE_HIGH);
         lvl_b_nxt = (lvl_cfg.force_mode == trb_pkg::FORCE_HIGH);
      end
   end

   trb_pwm u_pwm_a (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .period_64(lvl_cfg.period_64),
      .index(idx_a),
      .pwm_out(pwm_a)
   );

   trb_pwm u_pwm_b (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .period_64(lvl_cfg.period_64),
      .index(idx_b),
      .pwm_out(pwm_b)
   );

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         div_r <= '0;
         post_gap_r <= 1'b0;
         lvl_a_r <= 1'b0;
         lvl_b_r <= 1'b0;
      end
      else
      begin
         div_r <= div_nxt;
         post_gap_r <= post_gap_nxt;
         lvl_a_r <= lvl_a_nxt;
         lvl_b_r <= lvl_b_nxt;
      end
   end

   assign button_status = status_r;
   assign report_valid = rep_v_r;
   assign report_index = rep_i_r;
   assign level_a_pin = lvl_a_r;
   assign level_b_pin = lvl_b_r;
   assign buzzer_pin = bz_out_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_only_scan;
      @(posedge sys_clk) disable iff (sys_rst)
      !scan_strobe |=> $stable(touched_r) && $stable(rep_v_r);
   endproperty
   a_only_scan: assert property (p_only_scan) else $error("state changed outside scan");
   property p_touch;
      @(posedge sys_clk) disable iff (sys_rst)
      scan_strobe && {1'b0, tick_of[0]} >= on_lvl |=> touched_r[0];
   endproperty
   a_touch: assert property (p_touch) else $error("touch at threshold missed");
   property p_release;
      @(posedge sys_clk) disable iff (sys_rst)
      scan_strobe && touched_r[0] && {1'b0, tick_of[0]} >= off_lvl |=> touched_r[0];
   endproperty
   a_release: assert property (p_release) else $error("release above low level");
   // Status follows a mode change only at the next scan
   property p_one;
      @(posedge sys_clk) disable iff (sys_rst)
      lvl_cfg.report_mode != trb_pkg::MODE_ALL && scan_strobe |=> $onehot0(status_r);
   endproperty
   a_one: assert property (p_one) else $error("more than one button reported");
   property p_first;
      @(posedge sys_clk) disable iff (sys_rst)
      lvl_cfg.report_mode == trb_pkg::MODE_FIRST && rep_v_r && touched_nxt[rep_i_r] |=> $stable(rep_i_r);
   endproperty
   a_first: assert property (p_first) else $error("first mode report changed");
   property p_gap;
      @(posedge sys_clk) disable iff (sys_rst)
      scan_strobe && gap_r && (|touched_nxt) |=> rep_v_r;
   endproperty
   a_gap: assert property (p_gap) else $error("report missing after idle scan");
   property p_idle;
      @(posedge sys_clk) disable iff (sys_rst)
      scan_strobe && !(|touched_nxt) |=> !rep_v_r;
   endproperty
   a_idle: assert property (p_idle) else $error("report held with no touch");
   property p_buz;
      @(posedge sys_clk) disable iff (sys_rst)
      bz_r == trb_pkg::BZ_IDLE && !buz_cfg.enable |=> bz_r == trb_pkg::BZ_IDLE;
   endproperty
   a_buz: assert property (p_buz) else $error("buzzer started while disabled");
   property p_force;
      @(posedge sys_clk) disable iff (sys_rst)
      forcing && lvl_cfg.force_mode == trb_pkg::FORCE_LOW |=> !level_a_pin && !level_b_pin;
   endproperty
   a_force: assert property (p_force) else $error("forced low not held");
endmodule

//--- rtl/trb_pkg.sv
// Package: constants, enums and structs for the touch report level PWM buzzer block.
// Assumes a 40 MHz system clock; the PWM tick runs at 2 MHz derived from it.
package trb_pkg;
   localparam int NUM_BTN = 8;
   localparam int TICK_W = 16;
   localparam int CLK_HZ = 40000000;
   localparam int PWM_HZ = 2000000;
   localparam int PWM_DIV = CLK_HZ / PWM_HZ;
   localparam int PWM_DIV_W = 5;
   localparam int BUZ_PH_MS = 15;
   localparam int BUZ_F1_HZ = 4000;
   localparam int BUZ_F2_HZ = 8000;
   localparam int BUZ_PH_CYC = (CLK_HZ / 1000) * BUZ_PH_MS;
   localparam int BUZ_HALF1 = CLK_HZ / (2 * BUZ_F1_HZ);
   localparam int BUZ_HALF2 = CLK_HZ / (2 * BUZ_F2_HZ);
   localparam int BUZ_CNT_W = 24;
   localparam logic [7:0] PER64_MAX = 8'h3f;
   localparam logic [1:0] MODE_ALL = 2'h0;
   localparam logic [1:0] MODE_FIRST = 2'h1;
   localparam logic [1:0] MODE_STRONG = 2'h2;
   localparam logic [1:0] FORCE_NONE = 2'h0;
   localparam logic [1:0] FORCE_LOW = 2'h1;
   localparam logic [1:0] FORCE_HIGH = 2'h2;
   localparam logic [1:0] FORCE_IDLE = 2'h3;

   typedef enum logic [2:0] {
      BZ_IDLE = 3'b001,
      BZ_PH1 = 3'b010,
      BZ_PH2 = 3'b100
   } trb_buz_e;

   typedef struct packed {
      logic enable;
      logic idle_level;
      logic [BUZ_CNT_W-1:0] half1;
      logic [BUZ_CNT_W-1:0] half2;
      logic [BUZ_CNT_W-1:0] dur1;
      logic [BUZ_CNT_W-1:0] dur2;
   } trb_buz_cfg_s;

   typedef struct packed {
      logic period_64;
      logic [7:0] idle_index;
      logic [1:0] report_mode;
      logic [1:0] force_mode;
      logic idle_gap;
   } trb_lvl_cfg_s;
endpackage

//--- rtl/trb_pwm.sv
// PWM generator: 8-bit counter advanced on a 2 MHz tick, period 256 or 64.
// Assumes tick is a one-cycle pulse from the same clock.
`timescale 1ns/1ps
module trb_pwm (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic period_64,
   input wire logic [7:0] index,
   output logic pwm_out
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic out_r;
   logic out_nxt;
   logic [8:0] width;

   // ----------------------------------------
   // Counter and compare
   // ----------------------------------------
   always_comb
   begin
      // Index 0 is width 0, otherwise n+1 counts
      width = (index == 8'h00) ? 9'h000 : ({1'b0, index} + 9'h001);
      cnt_nxt = cnt_r;
      if (tick)
      begin
         if (period_64 && cnt_r >= trb_pkg::PER64_MAX)
            cnt_nxt = 8'h00;
         else
            cnt_nxt = cnt_r + 8'h01;
      end
      // High from period start for width counts
      out_nxt = ({1'b0, cnt_nxt} < width);
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt_r <= 8'h00;
         out_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         out_r <= out_nxt;
      end
   end

   assign pwm_out = out_r;

   // Checked after a tick, since after a switch into the short period the counter wraps to 0 only at its next tick
   property p_period64;
      @(posedge sys_clk) disable iff (sys_rst)
      period_64 && tick |=> cnt_r <= trb_pkg::PER64_MAX;
   endproperty
   a_period64: assert property (p_period64) else $error("pwm counter over 64 period");
   property p_zero;
      @(posedge sys_clk) disable iff (sys_rst)
      (index == 8'h00) [*2] |-> !out_r;
   endproperty
   a_zero: assert property (p_zero) else $error("index 0 gave nonzero pulse");
endmodule

//--- sim/trb_host_meter.sv
// Host model: mean of a level pin over one PWM period, as an RC filter sees it.
// Assumes the PWM tick is trb_pkg::PWM_DIV system clocks apart.
`timescale 1ns/1ps
module trb_host_meter (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic level_pin,
   input wire logic period_64,
   output logic [15:0] mean_count,
   output logic [15:0] rise_count
);
   logic [15:0] win_r;
   logic [15:0] hi_r;
   logic [15:0] rise_r;
   logic last_r;
   logic [15:0] win_len;
   logic hi_in;
   logic rise_in;

   assign win_len = period_64 ? 16'(64 * trb_pkg::PWM_DIV) : 16'(256 * trb_pkg::PWM_DIV);
   assign hi_in = (level_pin === 1'b1);
   assign rise_in = hi_in & ~last_r;

   // A window of exactly one period gives the same mean at any phase
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         win_r <= 16'h0000;
         hi_r <= 16'h0000;
         rise_r <= 16'h0000;
         last_r <= 1'b0;
         mean_count <= 16'h0000;
         rise_count <= 16'h0000;
      end
      else
      begin
         last_r <= hi_in;
         if (win_r >= win_len - 16'h0001)
         begin
            win_r <= 16'h0000;
            hi_r <= 16'h0000;
            rise_r <= 16'h0000;
            mean_count <= hi_r + {15'h0000, hi_in};
            rise_count <= rise_r + {15'h0000, rise_in};
         end
         else
         begin
            win_r <= win_r + 16'h0001;
            hi_r <= hi_r + {15'h0000, hi_in};
            rise_r <= rise_r + {15'h0000, rise_in};
         end
      end
   end
endmodule

//--- sim/touch_report_level_pwm_buzzer_test.sv
// Testbench: touch detection, reporting modes, level PWM duty and buzzer tone.
// Assumes trb_top with a 40 MHz clock; buzzer counts shortened through buz_cfg.
`timescale 1ns/1ps
module touch_report_level_pwm_buzzer_test;
   localparam int DIV = trb_pkg::PWM_DIV;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic scan_strobe = 1'b0;
   logic [7:0][15:0] tk = '0;
   logic [7:0][7:0] lix = '0;
   logic [7:0] ma = 8'h01;
   logic [7:0] mb = 8'h00;
   trb_pkg::trb_lvl_cfg_s lc = '0;
   trb_pkg::trb_buz_cfg_s bc = '0;
   logic [127:0] sensor_ticks = '0;
   logic [15:0] threshold = 16'h0064;
   logic [15:0] hysteresis = 16'h000a;
   logic [63:0] button_level_index = '0;
   logic [7:0] map_a = 8'h01;
   logic [7:0] map_b = 8'h00;
   trb_pkg::trb_lvl_cfg_s lvl_cfg = '0;
   trb_pkg::trb_buz_cfg_s buz_cfg = '0;
   logic [7:0] button_status;
   logic report_valid;
   logic [2:0] report_index;
   logic level_a_pin;
   logic level_b_pin;
   logic buzzer_pin;
   logic [15:0] mean_a;
   logic [15:0] mean_b;
   logic [15:0] rise_a;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;

   always #12.5 sys_clk = ~sys_clk;

   trb_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .scan_strobe(scan_strobe), .sensor_ticks(sensor_ticks),
      .threshold(threshold), .hysteresis(hysteresis), .button_level_index(button_level_index),
      .map_a(map_a), .map_b(map_b), .lvl_cfg(lvl_cfg), .buz_cfg(buz_cfg), .button_status(button_status),
      .report_valid(report_valid), .report_index(report_index), .level_a_pin(level_a_pin),
      .level_b_pin(level_b_pin), .buzzer_pin(buzzer_pin));
   trb_host_meter u_meter_a (.sys_clk(sys_clk), .sys_rst(sys_rst), .level_pin(level_a_pin),
      .period_64(lvl_cfg.period_64), .mean_count(mean_a), .rise_count(rise_a));
   trb_host_meter u_meter_b (.sys_clk(sys_clk), .sys_rst(sys_rst), .level_pin(level_b_pin),
      .period_64(lvl_cfg.period_64), .mean_count(mean_b), .rise_count());

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic report_and_stop();
      if (mismatches == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic drive(input logic s);
      @(posedge sys_clk);
      sensor_ticks <= tk;
      button_level_index <= lix;
      map_a <= ma;
      map_b <= mb;
      lvl_cfg <= lc;
      buz_cfg <= bc;
      scan_strobe <= s;
      @(posedge sys_clk);
      scan_strobe <= 1'b0;
      #1;
   endtask

   task automatic scan();
      drive(1'b1);
   endtask

   task automatic release_all();
      tk = '0;
      repeat (3) scan();
   endtask

   task automatic settle(input logic p64);
      repeat ((p64 ? 64 : 256) * DIV * 2 + 40) @(posedge sys_clk);
      #1;
   endtask

   task automatic watch(input int n, output int tog, output int t1, output int t2, output int last);
      logic prev;
      tog = 0;
      t1 = 0;
      t2 = 0;
      last = 0;
      prev = buzzer_pin;
      for (int c = 1; c <= n; c++)
      begin
         @(posedge sys_clk);
         #1;
         if (buzzer_pin !== prev)
         begin
            tog++;
            last = c;
            t1 += (c >= 5 && c <= 35);
            t2 += (c >= 45 && c <= 75);
         end
         prev = buzzer_pin;
      end
   endtask

   task automatic count_hi(input int n, output int h);
      h = 0;
      repeat (n)
      begin
         @(posedge sys_clk);
         #1;
         h += (level_a_pin === 1'b1);
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_hyst();
      tk[0] = 16'h006d;
      scan();
      chk("below touch level", 16'h0000, button_status);
      tk[0] = 16'h006e;
      drive(1'b0);
      repeat (3) @(posedge sys_clk);
      chk("no update between scans", 16'h0000, {report_valid, button_status});
      scan();
      chk("touch at level", 16'h0001, button_status);
      tk[0] = 16'h005a;
      scan();
      chk("held at release edge", 16'h0001, button_status);
      tk[0] = 16'h0059;
      scan();
      chk("released", 16'h0000, button_status);
   endtask

   task automatic t_buz();
      int tog, t1, t2, last;
      bc = '{1'b1, 1'b1, 24'h000004, 24'h000002, 24'h000028, 24'h000028};
      release_all();
      tk[0] = 16'h00c8;
      scan();
      watch(120, tog, t1, t2, last);
      chk("tone toggles", 16'h0001, tog >= 27 && tog <= 33);
      chk("tone length", 16'h0001, last >= 76 && last <= 86);
      chk("first phase rate", 16'h0001, t1 >= 6 && t1 <= 9);
      chk("second phase rate", 16'h0001, t2 >= 13 && t2 <= 17);
      chk("idle after tone", 16'h0001, buzzer_pin);
      scan();
      watch(60, tog, t1, t2, last);
      chk("no repeat while held", 16'h0000, tog);
      bc.enable = 1'b0;
      bc.idle_level = 1'b0;
      release_all();
      tk[1] = 16'h00c8;
      scan();
      watch(100, tog, t1, t2, last);
      chk("disabled tone", 16'h0000, tog);
      chk("idle low", 16'h0000, buzzer_pin);
   endtask

   task automatic t_first();
      lc.report_mode = trb_pkg::MODE_FIRST;
      release_all();
      tk[2] = 16'h00c8;
      tk[5] = 16'h00c8;
      scan();
      chk("lowest of two", 16'h0002, report_index);
      tk[1] = 16'h00c8;
      scan();
      chk("later ignored", 16'h0002, report_index);
      chk("one reported", 16'h0004, button_status);
      tk[2] = 16'h0000;
      scan();
      chk("next at once", 16'h0001, report_valid && report_index == 3'h1);
      lc.idle_gap = 1'b1;
      tk[1] = 16'h0000;
      scan();
      chk("idle scan", 16'h0000, report_valid);
      scan();
      chk("next after gap", 16'h000d, {report_valid, report_index});
      lc.idle_gap = 1'b0;
   endtask

   task automatic t_strong();
      lc.report_mode = trb_pkg::MODE_STRONG;
      release_all();
      tk[0] = 16'h00c8;
      scan();
      tk[1] = 16'h012c;
      scan();
      chk("stronger replaces", 16'h0001, report_index);
      tk[2] = 16'h00fa;
      scan();
      chk("weaker ignored", 16'h0002, button_status);
      tk[0] = 16'h0000;
      scan();
      chk("kept on weak release", 16'h0001, report_valid && report_index == 3'h1);
      tk = '0;
      scan();
      chk("idle when none", 16'h0000, {report_valid, button_status});
   endtask

   task automatic t_all();
      lc.report_mode = trb_pkg::MODE_ALL;
      release_all();
      tk[0] = 16'h00c8;
      tk[3] = 16'h00c8;
      tk[7] = 16'h00c8;
      scan();
      chk("all flagged", 16'h0089, button_status);
      chk("one on level", 16'h0001, report_valid && report_index == 3'h0);
   endtask

   task automatic t_pwm();
      lc = '{1'b0, 8'h03, trb_pkg::MODE_FIRST, trb_pkg::FORCE_NONE, 1'b0};
      lix[1] = 8'h1e;
      lix[2] = 8'hff;
      ma = 8'h02;
      mb = 8'h06;
      release_all();
      settle(1'b0);
      chk("idle duty", 16'(4 * DIV), mean_a);
      tk[1] = 16'h00c8;
      scan();
      settle(1'b0);
      chk("duty a", 16'(31 * DIV), mean_a);
      chk("duty b", 16'(31 * DIV), mean_b);
      chk("pulse from start", 16'h0001, rise_a);
      tk[1] = 16'h0000;
      tk[2] = 16'h00c8;
      scan();
      scan();
      settle(1'b0);
      chk("full duty b", 16'(256 * DIV), mean_b);
      lc.period_64 = 1'b1;
      lc.idle_index = 8'h07;
      release_all();
      settle(1'b1);
      chk("idle duty 64", 16'(8 * DIV), mean_a);
      lix[1] = 8'h64;
      tk[1] = 16'h00c8;
      scan();
      settle(1'b1);
      chk("top index 64", 16'(64 * DIV), mean_a);
   endtask

   task automatic t_force();
      int h;
      bc = '{1'b1, 1'b0, 24'h000004, 24'h000002, 24'h000190, 24'h000190};
      ma = 8'h01;
      for (int k = 1; k <= 3; k++)
      begin
         lc = '{1'b1, (k == 3) ? 8'h3f : 8'h00, trb_pkg::MODE_FIRST, 2'(k), k == 1};
         lix[0] = (k == 1) ? 8'h3f : 8'h00;
         release_all();
         tk[0] = 16'h00c8;
         scan();
         repeat (10) @(posedge sys_clk);
         count_hi(690, h);
         chk("forced level", (k == 1) ? 16'h0000 : 16'h02b2, h);
         repeat (200) @(posedge sys_clk);
         count_hi(60, h);
         chk("level after tone", 16'h0000, h);
         scan();
         repeat (3) @(posedge sys_clk);
         count_hi(60, h);
         chk("level after gap", (k == 1) ? 16'h003c : 16'h0000, h);
      end
   endtask

   // ----------------------------------------
   // Sequence and hang guard
   // ----------------------------------------
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         mismatches++;
         report_and_stop();
      end
   end

   initial
   begin
      lc.report_mode = trb_pkg::MODE_FIRST;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("reset state", 16'h0000, {button_status, report_valid, report_index, level_a_pin, level_b_pin, buzzer_pin});
      t_hyst();
      t_buz();
      t_first();
      t_strong();
      t_all();
      t_pwm();
      t_force();
      report_and_stop();
   end
endmodule
